// ==== include/dcc_pkg.sv ====
// package: register map, field layout, reset values and states of the dram configuration block
package dcc_pkg;

  // ***************************************************************
  // register map (byte addresses, one aligned word each)
  // ***************************************************************
  localparam logic [31:0] ADDR_CONFIG = 32'h4800_0000;
  localparam logic [31:0] ADDR_CONTROL = 32'h4800_0004;
  localparam logic [31:0] ADDR_TIMING = 32'h4800_0008;

  // reset values and writable-bit masks
  localparam logic [31:0] RST_CONFIG = 32'h0000_000C;
  localparam logic [31:0] RST_CONTROL = 32'h4400_0040;
  localparam logic [31:0] RST_TIMING = 32'h0099_003F;
  localparam logic [31:0] WMASK_CONFIG = 32'h0006_DBFF;
  localparam logic [31:0] WMASK_CONTROL = 32'h7000_00F3;
  localparam logic [31:0] WMASK_TIMING = 32'h00FF_003F;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int CFG_ROW0_LSB = 17;
  localparam int CFG_ROW1_LSB = 14;
  localparam int CFG_COL0_LSB = 11;
  localparam int CFG_COL1_LSB = 8;
  localparam int CFG_ORDER0_LSB = 6;
  localparam int CFG_ORDER1_LSB = 4;
  localparam int CFG_TYPE_LSB = 1;
  localparam int CFG_WIDTH_BIT = 0;
  localparam int CTL_BUSY_BIT = 31;
  localparam int CTL_STROBE_LSB = 28;
  localparam int CTL_READ_BURST_STOP_ENABLE_BIT = 7;
  localparam int CTL_WRITE_BUFFER_ENABLE_BIT = 6;
  localparam int CTL_APDIS_BIT = 5;
  localparam int CTL_POWER_DOWN_ENABLE_BIT = 4;
  localparam int CTL_INIT_LSB = 0;
  localparam int TMG_RAS_LSB = 20;
  localparam int TMG_ARFC_LSB = 16;
  localparam int TMG_CAS_LSB = 4;
  localparam int TMG_RCD_LSB = 2;
  localparam int TMG_RP_LSB = 0;

  // ***************************************************************
  // encodings
  // ***************************************************************
  localparam logic [2:0] MEM_SDR = 3'h0;
  localparam logic [2:0] MEM_DDR2 = 3'h1;
  localparam logic [2:0] MEM_MSDR = 3'h2;
  localparam logic [2:0] MEM_MDDR = 3'h6;
  localparam logic [1:0] INIT_NORMAL = 2'h0;
  localparam logic [1:0] INIT_PALL = 2'h1;
  localparam logic [1:0] INIT_MRS = 2'h2;
  localparam logic [1:0] INIT_EMRS = 2'h3;
  localparam logic [1:0] PDN_NONE = 2'h0;
  localparam logic [1:0] PDN_PRECHARGE = 2'h1;
  localparam logic [1:0] PDN_ACTIVE = 2'h2;
  localparam logic [3:0] ROW_BITS_MIN = 4'hB;
  localparam logic [3:0] COL_BITS_MIN = 4'h8;

  // wait after a mode or extended mode register set, in clocks
  localparam logic [4:0] MODE_SET_WAIT = 5'h02;
  localparam logic [4:0] WAIT_ONE = 5'h01;

  // ***************************************************************
  // init command sequencer states
  // ***************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT = 3'b100
  } dcc_state_e;

endpackage

// ==== rtl/dcc_config_timing.sv ====
// dram controller configuration, control and timing registers with init command sequencer
//
// Overview of operation
// - Per bank, two-bit row width code selects 11, 12, 13 or 14 row bits.
// - Per bank, two-bit column width code selects 8, 9, 10 or 11 column bits.
// - Per bank, address order code 00 is bank-row-column, 01 is row-bank-column.
// - Memory type: 000 SDR, 001 DDR2, 010 mobile SDR, 110 mobile DDR; resets mobile DDR.
// - Bus width bit: 0 gives 32-bit bus, 1 gives 16-bit bus.
// - Control register bit 31 reads busy status: 0 idle, 1 busy.
// - Read burst stop enable takes effect only with mobile DDR selected.
// - Write buffer enable resets set; clearing it flushes buffered writes to memory.
// - Auto precharge bit: 0 enables auto precharge, 1 leaves rows open.
// - With power-down on, auto precharge gives precharge power-down, else active power-down.
// - Power-down bit: 0 no power-down control, 1 enables power-down control.
// - Init field 01, 10, 11 issues precharge-all, mode set, extended mode set.
// - Row active time is field plus one clocks, 1 to 16, reset 10.
// - Refresh recovery wait is field plus one clocks, 1 to 16.
// - CAS latency code 01, 10, 11 means 1, 2, 3 clocks; 00 reserved.
// - Row-to-column delay is field plus one clocks, 1 to 4.
// - Precharge-to-activate wait is field plus one clocks, 1 to 4.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps

module dcc_config_timing (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic engineBusy,
  input wire logic writeBufferEmpty,
  output logic [3:0] rowWidthBank0,
  output logic [3:0] rowWidthBank1,
  output logic [3:0] columnWidthBank0,
  output logic [3:0] columnWidthBank1,
  output logic [1:0] addressOrderBank0,
  output logic [1:0] addressOrderBank1,
  output logic [2:0] memoryTypeSelect,
  output logic busWidthSelect,
  output logic [2:0] strobeInputDelay,
  output logic readBurstStopActive,
  output logic writeBufferEnable,
  output logic writeBufferFlush,
  output logic autoPrechargeEnable,
  output logic [1:0] powerDownMode,
  output logic memCmdValid,
  output logic [1:0] memCmdCode,
  output logic [4:0] rowActiveCycles,
  output logic [4:0] refreshRecoveryCycles,
  output logic [1:0] casLatencyCycles,
  output logic [2:0] rasToCasCycles,
  output logic [2:0] prechargeCycles
);

  // ***************************************************************
  // state of the block
  // ***************************************************************
  typedef struct packed {
    dcc_pkg::dcc_state_e state;
    logic [4:0] waitCount;
    logic pending;
    logic [1:0] pendCode;
    logic [31:0] cfgReg;
    logic [31:0] ctlReg;
    logic [31:0] tmgReg;
    logic ack;
    logic [31:0] readData;
    logic cmdValid;
    logic [1:0] cmdCode;
    logic flush;
    logic busy;
    logic [3:0] row0;
    logic [3:0] row1;
    logic [3:0] col0;
    logic [3:0] col1;
    logic burstStop;
    logic [1:0] pdMode;
    logic apEnable;
    logic [4:0] rasCycles;
    logic [4:0] arfcCycles;
    logic [1:0] casCycles;
    logic [2:0] rcdCycles;
    logic [2:0] rpCycles;
  } dcc_state_s;

  dcc_state_s q;
  dcc_state_s next_q;

  // ***************************************************************
  // decode helpers
  // ***************************************************************
  // field value plus one, as a clock count
  function automatic logic [4:0] dcc_plus_one(input logic [3:0] code);
    dcc_plus_one = {1'b0, code} + 5'h01;
  endfunction

  // row or column width code to bit count
  function automatic logic [3:0] dcc_width(input logic [1:0] code, input logic [3:0] base);
    dcc_width = base + {2'h0, code};
  endfunction

  // merge a bus write into a register under byte lanes and writable mask
  function automatic logic [31:0] dcc_merge(input logic [31:0] old, input logic [31:0] wdata,
                                            input logic [3:0] sel, input logic [31:0] wmask);
    logic [31:0] laneMask;
    laneMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
    dcc_merge = (old & ~laneMask) | (wdata & laneMask);
  endfunction

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb
  begin
    logic request;
    logic [31:0] newCtl;
    logic [1:0] initCode;
    logic [2:0] fullWait;
    request = 1'b0;
    newCtl = 32'h0000_0000;
    initCode = 2'h0;
    fullWait = 3'h0;
    next_q = q;
    next_q.ack = 1'b0;
    next_q.cmdValid = 1'b0;
    next_q.flush = 1'b0;
    request = cyc_i & stb_i & ~q.ack;

    // wishbone slave: one wait cycle, then ack for a single cycle
    if (request)
    begin
      next_q.ack = 1'b1;
      next_q.readData = dcc_pkg::READ_ZERO;
      case (adr_i)
        dcc_pkg::ADDR_CONFIG:
        begin
          next_q.readData = q.cfgReg;
          if (we_i)
          begin
            next_q.cfgReg = dcc_merge(q.cfgReg, dat_i, sel_i, dcc_pkg::WMASK_CONFIG);
          end
        end
        dcc_pkg::ADDR_CONTROL:
        begin
          next_q.readData = q.ctlReg;
          next_q.readData[dcc_pkg::CTL_BUSY_BIT] = q.busy;
          if (we_i)
          begin
            newCtl = dcc_merge(q.ctlReg, dat_i, sel_i, dcc_pkg::WMASK_CONTROL);
            next_q.ctlReg = newCtl;
            if (q.ctlReg[dcc_pkg::CTL_WRITE_BUFFER_ENABLE_BIT] & ~newCtl[dcc_pkg::CTL_WRITE_BUFFER_ENABLE_BIT])
            begin
              next_q.flush = 1'b1;
            end
            initCode = newCtl[dcc_pkg::CTL_INIT_LSB +: 2];
            if (sel_i[0] && initCode != dcc_pkg::INIT_NORMAL)
            begin
              next_q.pending = 1'b1;
              next_q.pendCode = initCode;
            end
          end
        end
        dcc_pkg::ADDR_TIMING:
        begin
          next_q.readData = q.tmgReg;
          if (we_i)
          begin
            next_q.tmgReg = dcc_merge(q.tmgReg, dat_i, sel_i, dcc_pkg::WMASK_TIMING);
          end
        end
        default:
        begin
          next_q.readData = dcc_pkg::READ_ZERO;
        end
      endcase
    end

    case (q.state)
      dcc_pkg::ST_IDLE:
      begin
        if (q.pending)
        begin
          next_q.state = dcc_pkg::ST_ISSUE;
        end
      end
      dcc_pkg::ST_ISSUE:
      begin
        next_q.cmdValid = 1'b1;
        next_q.cmdCode = q.pendCode;
        if (~(request & we_i & sel_i[0] & (adr_i == dcc_pkg::ADDR_CONTROL)
              & (initCode != dcc_pkg::INIT_NORMAL)))
        begin
          next_q.pending = 1'b0;
        end
        fullWait = {1'b0, q.tmgReg[dcc_pkg::TMG_RP_LSB +: 2]} + 3'h1;
        if (q.pendCode == dcc_pkg::INIT_PALL)
        begin
          next_q.waitCount = {2'h0, fullWait};
        end
        else
        begin
          next_q.waitCount = dcc_pkg::MODE_SET_WAIT;
        end
        next_q.state = dcc_pkg::ST_WAIT;
      end
      dcc_pkg::ST_WAIT:
      begin
        if (q.waitCount <= dcc_pkg::WAIT_ONE)
        begin
          next_q.state = dcc_pkg::ST_IDLE;
        end
        else
        begin
          next_q.waitCount = q.waitCount - dcc_pkg::WAIT_ONE;
        end
      end
      default:
      begin
        next_q.state = dcc_pkg::ST_IDLE;
      end
    endcase

    // busy through command and wait, while the engine works, or while a disabled write buffer is not empty
    next_q.busy = (next_q.state != dcc_pkg::ST_IDLE) | next_q.pending | engineBusy
                  | (~q.ctlReg[dcc_pkg::CTL_WRITE_BUFFER_ENABLE_BIT] & ~writeBufferEmpty);

    next_q.row0 = dcc_width(q.cfgReg[dcc_pkg::CFG_ROW0_LSB +: 2], dcc_pkg::ROW_BITS_MIN);
    next_q.row1 = dcc_width(q.cfgReg[dcc_pkg::CFG_ROW1_LSB +: 2], dcc_pkg::ROW_BITS_MIN);
    next_q.col0 = dcc_width(q.cfgReg[dcc_pkg::CFG_COL0_LSB +: 2], dcc_pkg::COL_BITS_MIN);
    next_q.col1 = dcc_width(q.cfgReg[dcc_pkg::CFG_COL1_LSB +: 2], dcc_pkg::COL_BITS_MIN);
    // burst stop only with mobile ddr
    next_q.burstStop = q.ctlReg[dcc_pkg::CTL_READ_BURST_STOP_ENABLE_BIT]
                       & (q.cfgReg[dcc_pkg::CFG_TYPE_LSB +: 3] == dcc_pkg::MEM_MDDR);
    if (~q.ctlReg[dcc_pkg::CTL_POWER_DOWN_ENABLE_BIT])
    begin
      next_q.pdMode = dcc_pkg::PDN_NONE;
    end
    else if (q.ctlReg[dcc_pkg::CTL_APDIS_BIT])
    begin
      next_q.pdMode = dcc_pkg::PDN_ACTIVE;
    end
    else
    begin
      next_q.pdMode = dcc_pkg::PDN_PRECHARGE;
    end
    next_q.apEnable = ~q.ctlReg[dcc_pkg::CTL_APDIS_BIT];
    next_q.rasCycles = dcc_plus_one(q.tmgReg[dcc_pkg::TMG_RAS_LSB +: 4]);
    next_q.arfcCycles = dcc_plus_one(q.tmgReg[dcc_pkg::TMG_ARFC_LSB +: 4]);
    next_q.casCycles = q.tmgReg[dcc_pkg::TMG_CAS_LSB +: 2];
    next_q.rcdCycles = 3'(dcc_plus_one({2'h0, q.tmgReg[dcc_pkg::TMG_RCD_LSB +: 2]}));
    next_q.rpCycles = 3'(dcc_plus_one({2'h0, q.tmgReg[dcc_pkg::TMG_RP_LSB +: 2]}));

    // synchronous reset
    if (~resetn)
    begin
      next_q = '0;
      next_q.state = dcc_pkg::ST_IDLE;
      next_q.cfgReg = dcc_pkg::RST_CONFIG;
      next_q.ctlReg = dcc_pkg::RST_CONTROL;
      next_q.tmgReg = dcc_pkg::RST_TIMING;
      next_q.apEnable = ~dcc_pkg::RST_CONTROL[dcc_pkg::CTL_APDIS_BIT];
    end
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    q <= next_q;
  end

  // ***************************************************************
  // outputs, all straight from state
  // ***************************************************************
  assign dat_o = q.readData;
  assign ack_o = q.ack;
  assign rowWidthBank0 = q.row0;
  assign rowWidthBank1 = q.row1;
  assign columnWidthBank0 = q.col0;
  assign columnWidthBank1 = q.col1;
  assign addressOrderBank0 = q.cfgReg[dcc_pkg::CFG_ORDER0_LSB +: 2];
  assign addressOrderBank1 = q.cfgReg[dcc_pkg::CFG_ORDER1_LSB +: 2];
  assign memoryTypeSelect = q.cfgReg[dcc_pkg::CFG_TYPE_LSB +: 3];
  assign busWidthSelect = q.cfgReg[dcc_pkg::CFG_WIDTH_BIT];
  assign strobeInputDelay = q.ctlReg[dcc_pkg::CTL_STROBE_LSB +: 3];
  assign readBurstStopActive = q.burstStop;
  assign writeBufferEnable = q.ctlReg[dcc_pkg::CTL_WRITE_BUFFER_ENABLE_BIT];
  assign writeBufferFlush = q.flush;
  assign autoPrechargeEnable = q.apEnable;
  assign powerDownMode = q.pdMode;
  assign memCmdValid = q.cmdValid;
  assign memCmdCode = q.cmdCode;
  assign rowActiveCycles = q.rasCycles;
  assign refreshRecoveryCycles = q.arfcCycles;
  assign casLatencyCycles = q.casCycles;
  assign rasToCasCycles = q.rcdCycles;
  assign prechargeCycles = q.rpCycles;

endmodule

// ==== sim/dcc_config_timing_asserts.sv ====
// checker: bus handshake and decode relations of the dram configuration block
`timescale 1ns/10ps
module dcc_config_timing_chk (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [31:0] adr_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire logic [2:0] memoryTypeSelect,
  input wire logic readBurstStopActive,
  input wire logic writeBufferEnable,
  input wire logic writeBufferFlush,
  input wire logic autoPrechargeEnable,
  input wire logic [1:0] powerDownMode,
  input wire logic memCmdValid,
  input wire logic [1:0] memCmdCode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic rdCtl;
  logic rdMiss;
  // read answers on the control word and on unmapped places
  assign rdCtl = ack_o && !we_i && adr_i == dcc_pkg::ADDR_CONTROL;
  assign rdMiss = ack_o && !we_i && adr_i != dcc_pkg::ADDR_CONFIG && adr_i != dcc_pkg::ADDR_CONTROL
    && adr_i != dcc_pkg::ADDR_TIMING;
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
  property p_ack_answer; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");
  property p_ctl_reserved; rdCtl |-> dat_o[27:8] == dcc_pkg::RST_CONTROL[27:8] && dat_o[3:2] == 2'h0; endproperty
  a_ctl_reserved: assert property (p_ctl_reserved) else $error("control reserved bits wrong");
  property p_unmapped; rdMiss |-> dat_o == dcc_pkg::READ_ZERO; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_pd_pre; powerDownMode == dcc_pkg::PDN_PRECHARGE |-> autoPrechargeEnable || $past(autoPrechargeEnable); endproperty
  a_pd_pre: assert property (p_pd_pre) else $error("precharge power-down without auto precharge");
  property p_pd_act; powerDownMode == dcc_pkg::PDN_ACTIVE |-> !autoPrechargeEnable || !$past(autoPrechargeEnable); endproperty
  a_pd_act: assert property (p_pd_act) else $error("active power-down with auto precharge");
  property p_read_burst_stop_enable; readBurstStopActive |-> memoryTypeSelect == dcc_pkg::MEM_MDDR
    || $past(memoryTypeSelect) == dcc_pkg::MEM_MDDR; endproperty
  a_read_burst_stop_enable: assert property (p_read_burst_stop_enable) else $error("burst stop active outside mobile ddr");
  property p_flush_off; writeBufferFlush |-> ##[0:1] !writeBufferEnable; endproperty
  a_flush_off: assert property (p_flush_off) else $error("flush while buffer enabled");
  property p_flush_pulse; writeBufferFlush |=> !writeBufferFlush; endproperty
  a_flush_pulse: assert property (p_flush_pulse) else $error("flush longer than one cycle");
  property p_cmd_pulse; memCmdValid |=> !memCmdValid; endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command valid held");
  property p_cmd_code; memCmdValid |-> memCmdCode != dcc_pkg::INIT_NORMAL; endproperty
  a_cmd_code: assert property (p_cmd_code) else $error("command issued with normal code");
endmodule
bind dcc_config_timing dcc_config_timing_chk dcc_config_timing_chk_inst (.core_clk, .resetn, .adr_i, .we_i,
  .cyc_i, .stb_i, .ack_o, .dat_o, .memoryTypeSelect, .readBurstStopActive, .writeBufferEnable,
  .writeBufferFlush, .autoPrechargeEnable, .powerDownMode, .memCmdValid, .memCmdCode);

// ==== sim/dcc_mem_model.sv ====
// partner model: controller core busy time and posted-write buffer drain
`timescale 1ns/10ps
module dcc_mem_model #(
  parameter int DRAIN = 12,
  parameter int CMD_BUSY = 3
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic fillReq,
  input wire logic writeBufferFlush,
  input wire logic memCmdValid,
  output logic engineBusy,
  output logic writeBufferEmpty
);
  int words;
  int busyLeft;
  logic draining;
  // core busy while a command runs; buffer drains one word a clock
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      words <= 0;
      busyLeft <= 0;
      draining <= 1'b0;
    end
    else
    begin
      busyLeft <= memCmdValid ? CMD_BUSY : (busyLeft > 0 ? busyLeft - 1 : 0);
      if (fillReq)
        words <= DRAIN;
      else if (draining && words > 0)
        words <= words - 1;
      draining <= writeBufferFlush ? 1'b1 : (words > 1 ? draining : 1'b0);
    end
  end
  assign engineBusy = busyLeft != 0;
  assign writeBufferEmpty = words == 0;
endmodule

// ==== sim/tb_top.sv ====
// testbench: register access, decodes, buffer flush and init commands
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_top;
  logic core_clk, resetn, we_i, cyc_i, stb_i, ack_o, fillReq, engineBusy, writeBufferEmpty;
  logic [31:0] adr_i, dat_i, dat_o, rd, cfg, tm;
  logic [3:0] sel_i, wsel, rowWidthBank0, rowWidthBank1, columnWidthBank0, columnWidthBank1;
  logic [1:0] addressOrderBank0, addressOrderBank1, powerDownMode, memCmdCode, casLatencyCycles;
  logic [2:0] memoryTypeSelect, strobeInputDelay, rasToCasCycles, prechargeCycles;
  logic busWidthSelect, readBurstStopActive, writeBufferEnable, writeBufferFlush, autoPrechargeEnable, memCmdValid;
  logic [4:0] rowActiveCycles, refreshRecoveryCycles;
  logic [2:0] typeTab [4] = '{dcc_pkg::MEM_SDR, dcc_pkg::MEM_DDR2, dcc_pkg::MEM_MSDR, dcc_pkg::MEM_MDDR};
  int error_cnt = 0;
  int num_checks = 0;
  int cmdCnt = 0;
  int flushCnt = 0;
  int n0;
  dcc_config_timing dcc_config_timing_inst (.core_clk, .resetn, .adr_i, .dat_i, .dat_o, .sel_i, .we_i, .cyc_i,
    .stb_i, .ack_o, .engineBusy, .writeBufferEmpty, .rowWidthBank0, .rowWidthBank1, .columnWidthBank0,
    .columnWidthBank1, .addressOrderBank0, .addressOrderBank1, .memoryTypeSelect, .busWidthSelect,
    .strobeInputDelay, .readBurstStopActive, .writeBufferEnable, .writeBufferFlush, .autoPrechargeEnable,
    .powerDownMode, .memCmdValid, .memCmdCode, .rowActiveCycles, .refreshRecoveryCycles, .casLatencyCycles,
    .rasToCasCycles, .prechargeCycles);
  dcc_mem_model dcc_mem_model_inst (.core_clk, .resetn, .fillReq, .writeBufferFlush, .memCmdValid, .engineBusy,
    .writeBufferEmpty);
  // clock, pulse counters and watchdog
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(negedge core_clk)
  begin
    if (memCmdValid === 1'b1) cmdCnt++;
    if (writeBufferFlush === 1'b1) flushCnt++;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    end_sim();
  end
  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one classic wishbone cycle; read data lands in rd
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= wsel;
    @(negedge core_clk);
    while (ack_o !== 1'b1 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 20)
    begin
      error_cnt++;
      end_sim();
    end
    rd = dat_o;
    @(posedge core_clk);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(negedge core_clk);
  endtask
  // poll the busy bit until idle
  task automatic wait_idle;
    int n;
    n = 0;
    rd = 32'h8000_0000;
    while (rd[31] !== 1'b0 && n < 40)
    begin
      wb(1'b0, dcc_pkg::ADDR_CONTROL, 32'h0);
      n++;
    end
    if (n >= 40)
    begin
      error_cnt++;
      end_sim();
    end
  endtask
  // main sequence
  initial
  begin
    resetn = 1'b0;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 32'h0;
    dat_i = 32'h0;
    sel_i = 4'hF;
    wsel = 4'hF;
    fillReq = 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(negedge core_clk);
    wb(1'b0, dcc_pkg::ADDR_CONFIG, 32'h0);
    `CHK("config", dcc_pkg::RST_CONFIG, rd)
    wb(1'b0, dcc_pkg::ADDR_CONTROL, 32'h0);
    `CHK("control", dcc_pkg::RST_CONTROL, rd)
    wb(1'b0, dcc_pkg::ADDR_TIMING, 32'h0);
    `CHK("timing", dcc_pkg::RST_TIMING, rd)
    `CHK("ras", 5'h0A, rowActiveCycles)
    `CHK("write_buffer_enable", 1'b1, writeBufferEnable)
    wb(1'b1, 32'h4800_0010, 32'hFFFF_FFFF);
    wb(1'b0, 32'h4800_0010, 32'h0);
    `CHK("unmapped", dcc_pkg::READ_ZERO, rd)
    for (int k = 0; k < 4; k++)
    begin
      cfg = {13'h0, 2'(k), 1'b0, 2'(3 - k), 1'b0, 2'(k), 1'b0, 2'(3 - k), 2'(k % 2), 2'((k + 1) % 2), typeTab[k],
        1'(k % 2)};
      wb(1'b1, dcc_pkg::ADDR_CONFIG, cfg);
      wb(1'b0, dcc_pkg::ADDR_CONFIG, 32'h0);
      `CHK("cfg", cfg, rd)
      `CHK("row0", 4'(11 + k), rowWidthBank0)
      `CHK("row1", 4'(14 - k), rowWidthBank1)
      `CHK("col0", 4'(8 + k), columnWidthBank0)
      `CHK("col1", 4'(11 - k), columnWidthBank1)
      `CHK("order", {2'(k % 2), 2'((k + 1) % 2)}, {addressOrderBank0, addressOrderBank1})
      `CHK("type", typeTab[k], memoryTypeSelect)
      `CHK("width", 1'(k % 2), busWidthSelect)
    end
    for (int j = 0; j < 3; j++)
    begin
      tm = {8'h0, 4'(15 - 7 * j), 4'(5 * j), 10'h0, 2'(j + 1), 2'(j + 1), 2'(2 - j)};
      wb(1'b1, dcc_pkg::ADDR_TIMING, tm);
      wb(1'b0, dcc_pkg::ADDR_TIMING, 32'h0);
      `CHK("tmg", tm, rd)
      `CHK("ras", 5'(16 - 7 * j), rowActiveCycles)
      `CHK("arfc", 5'(5 * j + 1), refreshRecoveryCycles)
      `CHK("cas", 2'(j + 1), casLatencyCycles)
      `CHK("rcd", 3'(j + 2), rasToCasCycles)
      `CHK("rp", 3'(3 - j), prechargeCycles)
    end
    for (int m = 0; m < 4; m++)
    begin
      wb(1'b1, dcc_pkg::ADDR_CONTROL, {1'b0, 3'h3, 20'h0, 2'h3, 2'(m), 4'h0});
      `CHK("dqs", 3'h3, strobeInputDelay)
      `CHK("read_burst_stop_enable", 1'b1, readBurstStopActive)
      `CHK("apen", 1'(m < 2), autoPrechargeEnable)
      `CHK("pdn", (m % 2 == 0) ? dcc_pkg::PDN_NONE : (m < 2 ? dcc_pkg::PDN_PRECHARGE : dcc_pkg::PDN_ACTIVE),
        powerDownMode)
    end
    wb(1'b1, dcc_pkg::ADDR_CONFIG, 32'h0);
    @(negedge core_clk);
    `CHK("read_burst_stop_enable sdr", 1'b0, readBurstStopActive)
    wsel = 4'h2;
    wb(1'b1, dcc_pkg::ADDR_CONFIG, 32'hFFFF_FFFF);
    wsel = 4'hF;
    wb(1'b0, dcc_pkg::ADDR_CONFIG, 32'h0);
    `CHK("lane", 32'h0000_DB00, rd)
    `CHK("lane col0", 4'hB, columnWidthBank0)
    wb(1'b1, dcc_pkg::ADDR_CONFIG, dcc_pkg::RST_CONFIG);
    wb(1'b1, dcc_pkg::ADDR_CONTROL, 32'hBFFF_FF4C);
    wb(1'b0, dcc_pkg::ADDR_CONTROL, 32'h0);
    `CHK("ctl rsvd", {1'b0, 3'h3, dcc_pkg::RST_CONTROL[27:8], 8'h40}, rd)
    @(posedge core_clk);
    fillReq <= 1'b1;
    @(posedge core_clk);
    fillReq <= 1'b0;
    wb(1'b1, dcc_pkg::ADDR_CONTROL, 32'h3000_0000);
    `CHK("flush", 1, flushCnt)
    `CHK("write_buffer_enable off", 1'b0, writeBufferEnable)
    wb(1'b0, dcc_pkg::ADDR_CONTROL, 32'h0);
    `CHK("drain busy", 1'b1, rd[31])
    wait_idle();
    `CHK("drained", 1'b1, writeBufferEmpty)
    wb(1'b1, dcc_pkg::ADDR_CONTROL, 32'h3000_0040);
    for (int i = 0; i < 4; i++)
    begin
      n0 = cmdCnt;
      wb(1'b1, dcc_pkg::ADDR_CONTROL, 32'h3000_0040 + 32'((i == 0) ? 1 : i));
      wb(1'b0, dcc_pkg::ADDR_CONTROL, 32'h0);
      `CHK("busy", 1'b1, rd[31])
      `CHK("init rd", 2'((i == 0) ? 1 : i), rd[1:0])
      wait_idle();
      `CHK("cmds", n0 + 1, cmdCnt)
      `CHK("code", 2'((i == 0) ? 1 : i), memCmdCode)
    end
    n0 = cmdCnt;
    wsel = 4'hE;
    wb(1'b1, dcc_pkg::ADDR_CONTROL, 32'h3000_0043);
    wsel = 4'hF;
    wb(1'b0, dcc_pkg::ADDR_CONTROL, 32'h0);
    `CHK("lane0 idle", 1'b0, rd[31])
    wb(1'b1, dcc_pkg::ADDR_CONTROL, 32'h3000_0040);
    wb(1'b0, dcc_pkg::ADDR_CONTROL, 32'h0);
    `CHK("normal idle", 1'b0, rd[31])
    `CHK("no cmd", n0, cmdCnt)
    end_sim();
  end
endmodule
